// >>> src/tcs_torque_control_supervisor.sv
// Torque control supervisor with Avalon-MM register slave and interrupt.
// Overview of operation
// [RL1] Torque sign is command sign, inverted when running reverse.
// [RL2] Torque mode field: 0 speed, 2 torque current, 3 torque command.
// [RL3] In torque modes the cancel input forces speed control while active.
// [RL4] Forward overspeed level is max frequency times forward limit times 120 %.
// [RL5] Reverse overspeed level is max frequency times reverse limit times 120 %.
// [RL6] Output frequency above the applicable level trips and removes drive.
// [RL7] Torque control has no ramps; run on starts torque output at once.
// [RL8] Torque control run off removes drive at once, motor coasts.
// [RL9] Search select not 2: torque start begins at zero frequency.
// [RL10] Search select 2: estimate speed, resume at it, then torque control.
// [RL11] Thermistor mode 0 off; mode 1 trips when voltage exceeds level.
// [RL12] Thermistor mode 2 raises overheat output and keeps running.
// [RL13] Thermistor mode 3 trips when motor temperature exceeds protection level.
// [RL14] Modes 1 and 2 work for every motor; mode 3 only for motor one.
// [RL15] Divided thermistor voltage compared with level of 0.00 to 5.00 V.
// [RL16] Software sets level to Rp over 27000 plus Rp times 10.5 V.
// [RL17] Droop accepts -60.0 to 0.0 Hz; frequency falls as load rises.
//
// Design decisions made here: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module tcs_torque_control_supervisor (
   input wire logic i_clk_sys,
   input wire logic i_sys_rst,
   input wire logic [5:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   input wire logic i_run_forward_input,
   input wire logic i_run_reverse_input,
   input wire logic i_torque_cancel_input,
   input wire logic i_torque_cmd_negative,
   input wire logic [15:0] i_output_freq,
   input wire logic [8:0] i_thermistor_input_terminal,
   input wire logic [7:0] i_motor_temp,
   input wire logic [1:0] i_motor_select,
   input wire logic [7:0] i_load_torque_pct,
   input wire logic i_search_done,
   input wire logic [15:0] i_search_freq,
   output logic o_drive_enable,
   output logic o_torque_control,
   output logic o_torque_positive,
   output logic o_ramp_bypass,
   output logic o_search_request,
   output logic [15:0] o_start_freq,
   output logic o_overspeed_fault,
   output logic o_motor_protection_alarm,
   output logic o_motor_overheat_output,
   output logic signed [15:0] o_droop_offset,
   output logic o_irq
);
   // ****************************************
   // Register slave
   // ****************************************
   tcs_pkg::tcs_cfg_t cfg_reg, cfg_next;
   logic [3:0] irq_stat_reg, irq_stat_next;
   logic [3:0] irq_en_reg, irq_en_next;
   logic wait_reg, wait_next;
   logic [31:0] rdata_reg, rdata_next;
   logic irq_reg, irq_next;
   logic ovs_reg, ovs_next;
   logic prot_reg, prot_next;
   logic heat_reg, heat_next;
   tcs_pkg::tcs_state_t st_reg, st_next;
   logic [3:0] ev;
   logic wr_ok;
   logic signed [10:0] droop_in;

   // A write lands at the edge where waitrequest is seen low.
   assign wr_ok = i_avs_write && !wait_reg;
   assign droop_in = i_avs_writedata[10:0];

   // Next values of the configuration and bus answer.
   always_comb begin
      cfg_next = cfg_reg;
      wait_next = !((i_avs_read || i_avs_write) && wait_reg);
      rdata_next = 32'h0;
      if (wr_ok) begin
         case (i_avs_address)
            tcs_pkg::OFS_MODE: begin
               cfg_next.trq_mode = i_avs_writedata[tcs_pkg::MODE_TRQ_LSB +: 2]; // RL2
               cfg_next.thm_mode = i_avs_writedata[tcs_pkg::MODE_THM_LSB +: 2];
               cfg_next.srch_sel = i_avs_writedata[tcs_pkg::MODE_SRCH_LSB +: 2];
            end
            tcs_pkg::OFS_FMAX: cfg_next.fmax = i_avs_writedata[15:0];
            tcs_pkg::OFS_SPDLIM: begin
               cfg_next.lim_fwd = i_avs_writedata[7:0];
               cfg_next.lim_rev = i_avs_writedata[tcs_pkg::LIM_REV_LSB +: 8];
            end
            tcs_pkg::OFS_THLVL: begin
               // Detect level is clamped to 5.00 V.
               cfg_next.det_lvl = (i_avs_writedata[8:0] > tcs_pkg::THL_MAX) ?
                  tcs_pkg::THL_MAX : i_avs_writedata[8:0]; // RL15
               cfg_next.prot_lvl = i_avs_writedata[tcs_pkg::THL_PROT_LSB +: 8];
            end
            tcs_pkg::OFS_DROOP: begin
               // Droop is held inside -60.0 to 0.0 Hz.
               if (droop_in > 11'sd0) begin
                  cfg_next.droop = 11'sd0; // RL17
               end else if (droop_in < tcs_pkg::DROOP_MIN) begin
                  cfg_next.droop = tcs_pkg::DROOP_MIN; // RL17
               end else begin
                  cfg_next.droop = droop_in;
               end
            end
            default: cfg_next = cfg_reg;
         endcase
      end
      if (i_avs_read && wait_reg) begin
         case (i_avs_address)
            tcs_pkg::OFS_MODE: rdata_next = {26'h0, cfg_reg.srch_sel, cfg_reg.thm_mode,
               cfg_reg.trq_mode};
            tcs_pkg::OFS_FMAX: rdata_next = {16'h0, cfg_reg.fmax};
            tcs_pkg::OFS_SPDLIM: rdata_next = {16'h0, cfg_reg.lim_rev, cfg_reg.lim_fwd};
            tcs_pkg::OFS_THLVL: rdata_next = {8'h0, cfg_reg.prot_lvl, 7'h0, cfg_reg.det_lvl};
            tcs_pkg::OFS_DROOP: rdata_next = {{21{cfg_reg.droop[10]}}, cfg_reg.droop};
            tcs_pkg::OFS_STATUS: rdata_next = {24'h0, st_reg == tcs_pkg::ST_SEARCH,
               o_torque_positive, o_torque_control, o_drive_enable, heat_reg, prot_reg,
               ovs_reg, i_search_done};
            tcs_pkg::OFS_IRQ_STAT: rdata_next = {28'h0, irq_stat_reg};
            tcs_pkg::OFS_IRQ_EN: rdata_next = {28'h0, irq_en_reg};
            default: rdata_next = 32'h0;
         endcase
      end
   end

   // Interrupt status: a new event wins over a clear in the same cycle.
   always_comb begin
      irq_en_next = irq_en_reg;
      irq_stat_next = irq_stat_reg;
      if (wr_ok && i_avs_address == tcs_pkg::OFS_IRQ_EN) begin
         irq_en_next = i_avs_writedata[3:0];
      end
      if (wr_ok && i_avs_address == tcs_pkg::OFS_IRQ_CLR) begin
         irq_stat_next = irq_stat_reg & ~i_avs_writedata[3:0];
      end
      irq_stat_next = irq_stat_next | ev;
      irq_next = |(irq_stat_next & irq_en_next);
   end

   // ****************************************
   // Mode, polarity and thresholds
   // ****************************************
   logic run_cmd, trq_sel, trq_act, trq_pos;
   logic [31:0] fwd_prod, rev_prod;
   logic [15:0] fwd_thr_reg, fwd_thr_next, rev_thr_reg, rev_thr_next;
   logic over_spd, thm_over, ntc_over;
   logic signed [19:0] droop_prod;

   // Exactly one direction input forms a run command.
   assign run_cmd = i_run_forward_input ^ i_run_reverse_input;
   assign trq_sel = (cfg_reg.trq_mode == tcs_pkg::TRQ_CURRENT) ||
      (cfg_reg.trq_mode == tcs_pkg::TRQ_TORQUE); // RL2
   assign trq_act = trq_sel && !i_torque_cancel_input; // RL3
   // Torque is positive when the command sign and the running direction agree.
   assign trq_pos = !(i_torque_cmd_negative ^ i_run_reverse_input); // RL1
   assign fwd_prod = 32'(cfg_reg.fmax) * 32'(cfg_reg.lim_fwd) * 32'(tcs_pkg::OVS_PCT);
   assign rev_prod = 32'(cfg_reg.fmax) * 32'(cfg_reg.lim_rev) * 32'(tcs_pkg::OVS_PCT);
   assign fwd_thr_next = 16'(fwd_prod / 32'(tcs_pkg::PCT_SQ)); // RL4
   assign rev_thr_next = 16'(rev_prod / 32'(tcs_pkg::PCT_SQ)); // RL5
   // The applicable level follows the running direction.
   assign over_spd = (i_run_forward_input && i_output_freq > fwd_thr_reg) ||
      (i_run_reverse_input && i_output_freq > rev_thr_reg); // RL6
   assign thm_over = i_thermistor_input_terminal > cfg_reg.det_lvl; // RL15
   assign ntc_over = (i_motor_select == 2'h0) && (i_motor_temp > cfg_reg.prot_lvl); // RL14
   // Both factors are widened first, so that full droop at full load keeps its sign.
   assign droop_prod = 20'(cfg_reg.droop) * 20'($signed({1'b0, i_load_torque_pct}));

   // ****************************************
   // Protection and run sequencer
   // ****************************************
   logic drv_next, tc_next, tpos_next, srq_next;
   logic [15:0] sfreq_next;
   logic signed [15:0] droop_next;
   logic clr_ovs, clr_prot;

   assign clr_ovs = wr_ok && i_avs_address == tcs_pkg::OFS_IRQ_CLR &&
      i_avs_writedata[tcs_pkg::EV_OVS];
   assign clr_prot = wr_ok && i_avs_address == tcs_pkg::OFS_IRQ_CLR &&
      i_avs_writedata[tcs_pkg::EV_PROT];

   // Trips latch until software clears them; a protection trip stays set while its cause remains.
   always_comb begin
      ev = 4'h0;
      ovs_next = ovs_reg;
      prot_next = prot_reg;
      if (clr_ovs) begin
         ovs_next = 1'b0;
      end
      if (clr_prot) begin
         prot_next = 1'b0;
      end
      if (st_reg != tcs_pkg::ST_IDLE && over_spd) begin
         ovs_next = 1'b1; // RL6
      end
      case (cfg_reg.thm_mode)
         tcs_pkg::THM_TRIP: if (thm_over) prot_next = 1'b1; // RL11
         tcs_pkg::THM_NTC: if (ntc_over) prot_next = 1'b1; // RL13
         default: prot_next = prot_next; // RL11
      endcase
      heat_next = (cfg_reg.thm_mode == tcs_pkg::THM_WARN) && thm_over; // RL12
      ev[tcs_pkg::EV_OVS] = ovs_next && !ovs_reg;
      ev[tcs_pkg::EV_PROT] = prot_next && !prot_reg;
      ev[tcs_pkg::EV_HEAT] = heat_next && !heat_reg;
      ev[tcs_pkg::EV_SRCH] = st_reg == tcs_pkg::ST_SEARCH && i_search_done;
   end

   // Run sequencer; a trip or run off stops output at once.
   always_comb begin
      st_next = st_reg;
      sfreq_next = o_start_freq;
      case (st_reg)
         tcs_pkg::ST_IDLE: begin
            if (run_cmd && !ovs_next && !prot_next) begin
               if (trq_act && cfg_reg.srch_sel == tcs_pkg::SRCH_ALWAYS) begin
                  st_next = tcs_pkg::ST_SEARCH; // RL10
               end else begin
                  st_next = tcs_pkg::ST_RUN; // RL7
                  sfreq_next = 16'h0; // RL9
               end
            end
         end
         tcs_pkg::ST_SEARCH: begin
            if (i_search_done) begin
               st_next = tcs_pkg::ST_RUN; // RL10
               sfreq_next = i_search_freq; // RL10
            end
         end
         tcs_pkg::ST_RUN: st_next = tcs_pkg::ST_RUN;
         default: st_next = tcs_pkg::ST_IDLE;
      endcase
      if (!run_cmd || ovs_next || prot_next) begin
         st_next = tcs_pkg::ST_IDLE; // RL8
      end
      drv_next = st_next == tcs_pkg::ST_RUN; // RL7
      tc_next = trq_act && st_next == tcs_pkg::ST_RUN;
      srq_next = st_next == tcs_pkg::ST_SEARCH;
      tpos_next = trq_pos; // RL1
      droop_next = 16'(droop_prod / 20'sd100); // RL17
   end

   // Registers of all groups.
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         cfg_reg <= '{trq_mode: tcs_pkg::MODE_RST[1:0], thm_mode: tcs_pkg::MODE_RST[3:2],
            srch_sel: tcs_pkg::MODE_RST[5:4], fmax: tcs_pkg::FMAX_RST,
            lim_fwd: tcs_pkg::LIM_RST, lim_rev: tcs_pkg::LIM_RST,
            det_lvl: tcs_pkg::THL_RST, prot_lvl: tcs_pkg::PROT_RST, droop: 11'sd0};
         wait_reg <= 1'b1;
         rdata_reg <= 32'h0;
         irq_stat_reg <= 4'h0;
         irq_en_reg <= 4'h0;
         irq_reg <= 1'b0;
         fwd_thr_reg <= 16'h0;
         rev_thr_reg <= 16'h0;
         ovs_reg <= 1'b0;
         prot_reg <= 1'b0;
         heat_reg <= 1'b0;
         st_reg <= tcs_pkg::ST_IDLE;
         o_drive_enable <= 1'b0;
         o_torque_control <= 1'b0;
         o_torque_positive <= 1'b1;
         o_search_request <= 1'b0;
         o_start_freq <= 16'h0;
         o_droop_offset <= 16'sd0;
      end else begin
         cfg_reg <= cfg_next;
         wait_reg <= wait_next;
         rdata_reg <= rdata_next;
         irq_stat_reg <= irq_stat_next;
         irq_en_reg <= irq_en_next;
         irq_reg <= irq_next;
         fwd_thr_reg <= fwd_thr_next;
         rev_thr_reg <= rev_thr_next;
         ovs_reg <= ovs_next;
         prot_reg <= prot_next;
         heat_reg <= heat_next;
         st_reg <= st_next;
         o_drive_enable <= drv_next;
         o_torque_control <= tc_next;
         o_torque_positive <= tpos_next;
         o_search_request <= srq_next;
         o_start_freq <= sfreq_next;
         o_droop_offset <= droop_next;
      end
   end

   assign o_avs_waitrequest = wait_reg;
   assign o_avs_readdata = rdata_reg;
   assign o_irq = irq_reg;
   assign o_ramp_bypass = o_torque_control; // RL7
   assign o_overspeed_fault = ovs_reg;
   assign o_motor_protection_alarm = prot_reg;
   assign o_motor_overheat_output = heat_reg;

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_sys_rst);

   sequence s_search;
      st_reg == tcs_pkg::ST_SEARCH && i_search_done;
   endsequence

   a_torque_sign: assert property (##1 o_torque_positive ==
      $past(!(i_torque_cmd_negative ^ i_run_reverse_input))) // RL1
      else $error("torque polarity wrong");
   a_cancel_speed: assert property (i_torque_cancel_input ##1 1'b1 |-> !o_torque_control) // RL3
      else $error("torque control not cancelled");
   // The level check starts after reset, once the registered level has been loaded.
   a_fwd_level: assert property (!i_sys_rst |=> fwd_thr_reg == $past(fwd_thr_next) &&
      (cfg_reg.lim_fwd != 8'h64 || cfg_reg.fmax != 16'h1770 || fwd_thr_next == 16'h1c20)) // RL4
      else $error("forward overspeed level wrong");
   a_ovs_trip: assert property (st_reg != tcs_pkg::ST_IDLE && over_spd |=>
      o_overspeed_fault && !o_drive_enable) // RL6
      else $error("overspeed did not trip");
   a_run_start: assert property (st_reg == tcs_pkg::ST_IDLE && run_cmd && trq_act &&
      cfg_reg.srch_sel != 2'h2 && !ovs_next && !prot_next |=> o_drive_enable &&
      o_start_freq == 16'h0) // RL9
      else $error("torque start not immediate at zero");
   a_run_stop: assert property (!run_cmd |=> !o_drive_enable) // RL8
      else $error("drive not removed on stop");
   // A finished search while the run still stands resumes at the estimate.
   a_search_seq: assert property ((s_search and (run_cmd && !ovs_next && !prot_next)) |=>
      o_drive_enable && o_start_freq == $past(i_search_freq)) // RL10
      else $error("search resume wrong");
   a_thm_trip: assert property (cfg_reg.thm_mode == 2'h1 && thm_over |=>
      o_motor_protection_alarm) // RL11
      else $error("thermistor trip missing");
   a_thm_warn: assert property (cfg_reg.thm_mode == 2'h2 && thm_over && !prot_reg |=>
      o_motor_overheat_output && !o_motor_protection_alarm) // RL12
      else $error("overheat output wrong");
   a_ntc_motor: assert property (cfg_reg.thm_mode == 2'h3 && i_motor_select != 2'h0 &&
      !prot_reg && !clr_prot |=> !o_motor_protection_alarm) // RL14
      else $error("ntc acted for other motor");
   a_droop_range: assert property (cfg_reg.droop <= 11'sd0 && cfg_reg.droop >= -11'sd600) // RL17
      else $error("droop out of range");
endmodule : tcs_torque_control_supervisor
`default_nettype wire

// >>> src/tcs_pkg.sv
// Package of constants and carrier types for the torque control supervisor.
package tcs_pkg;
   // Register byte offsets.
   localparam logic [5:0] OFS_MODE = 6'h00;
   localparam logic [5:0] OFS_FMAX = 6'h04;
   localparam logic [5:0] OFS_SPDLIM = 6'h08;
   localparam logic [5:0] OFS_THLVL = 6'h0c;
   localparam logic [5:0] OFS_DROOP = 6'h10;
   localparam logic [5:0] OFS_STATUS = 6'h14;
   localparam logic [5:0] OFS_IRQ_STAT = 6'h18;
   localparam logic [5:0] OFS_IRQ_CLR = 6'h1c;
   localparam logic [5:0] OFS_IRQ_EN = 6'h20;
   // Field positions.
   localparam int MODE_TRQ_LSB = 0;
   localparam int MODE_THM_LSB = 2;
   localparam int MODE_SRCH_LSB = 4;
   localparam int LIM_REV_LSB = 8;
   localparam int THL_PROT_LSB = 16;
   // Encodings of the mode fields.
   localparam logic [1:0] TRQ_SPEED = 2'h0;
   localparam logic [1:0] TRQ_CURRENT = 2'h2;
   localparam logic [1:0] TRQ_TORQUE = 2'h3;
   localparam logic [1:0] THM_OFF = 2'h0;
   localparam logic [1:0] THM_TRIP = 2'h1;
   localparam logic [1:0] THM_WARN = 2'h2;
   localparam logic [1:0] THM_NTC = 2'h3;
   localparam logic [1:0] SRCH_ALWAYS = 2'h2;
   // Limits: detect level in 10 mV steps, droop in 0.1 Hz steps.
   localparam logic [8:0] THL_MAX = 9'h1f4;
   localparam logic signed [10:0] DROOP_MIN = -11'sd600;
   localparam logic [6:0] OVS_PCT = 7'h78;
   localparam logic [13:0] PCT_SQ = 14'h2710;
   localparam logic [6:0] PCT = 7'h64;
   // Reset values.
   localparam logic [5:0] MODE_RST = 6'h00;
   localparam logic [15:0] FMAX_RST = 16'h1770;
   localparam logic [7:0] LIM_RST = 8'h64;
   localparam logic [8:0] THL_RST = 9'h08c;
   localparam logic [7:0] PROT_RST = 8'h96;
   // Interrupt bit positions.
   localparam int EV_OVS = 0;
   localparam int EV_PROT = 1;
   localparam int EV_HEAT = 2;
   localparam int EV_SRCH = 3;
   localparam int EV_N = 4;

   // Software settings.
   typedef struct packed {
      logic [1:0] trq_mode;
      logic [1:0] thm_mode;
      logic [1:0] srch_sel;
      logic [15:0] fmax;
      logic [7:0] lim_fwd;
      logic [7:0] lim_rev;
      logic [8:0] det_lvl;
      logic [7:0] prot_lvl;
      logic signed [10:0] droop;
   } tcs_cfg_t;

   // Run sequencer states.
   typedef enum logic [1:0] {ST_IDLE, ST_SEARCH, ST_RUN} tcs_state_t;
endpackage : tcs_pkg

// >>> verification/tcs_motor_model.sv
// Behavioural motor with embedded thermistor and idling speed estimator.
`timescale 1ns/1ps
`default_nettype none
module tcs_motor_model (
   input wire logic i_clk_sys,
   input wire logic i_sys_rst,
   input wire logic i_search_request,
   input wire logic [15:0] i_speed,
   input wire logic [15:0] i_rp_ohm,
   input wire logic [7:0] i_delay,
   output logic [8:0] o_therm_volt,
   output logic [15:0] o_output_freq,
   output logic o_search_done,
   output logic [15:0] o_search_freq
);
   logic [7:0] wait_reg;
   logic done_reg;
   // Divider voltage in 10 mV steps for the thermistor resistance in ohms.
   assign o_therm_volt = 9'((32'(i_rp_ohm) * 32'd1050) / (32'd27000 + 32'(i_rp_ohm)));
   assign o_output_freq = i_speed;
   // The estimator answers after a delay chosen by the bench, quick or slow.
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst || !i_search_request) begin
         wait_reg <= 8'h00;
         done_reg <= 1'b0;
      end else if (wait_reg >= i_delay) begin
         done_reg <= 1'b1;
      end else begin
         wait_reg <= wait_reg + 8'h01;
      end
   end
   // The estimate is only valid with done; before that it toggles every cycle.
   assign o_search_done = done_reg;
   assign o_search_freq = done_reg ? i_speed : (~i_speed ^ {16{wait_reg[0]}});
endmodule : tcs_motor_model
`default_nettype wire

// >>> verification/testbench.sv
// Self-checking random bench for the torque control supervisor.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin fails++; \
   $display("Error at %0t: got %0h want %0h", $time, (a), (e)); end end
module testbench;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic rd = 1'b0, wr = 1'b0, run_forward_input = 1'b0, run_reverse_input = 1'b0, cncl = 1'b0, neg = 1'b0;
   logic [5:0] adr = 6'h00;
   logic [31:0] wdat = 32'h0, rdat, q;
   logic [7:0] temp = 8'h00, load = 8'h00, dly = 8'h02;
   logic [1:0] msel = 2'h0;
   logic [15:0] spd = 16'h0, rp = 16'h0, sfo, ofr, sfr;
   logic [8:0] vth;
   logic wreq, drv, tctl, tpos, rbyp, sreq, ovs, alm, heat, irq, sdone;
   logic signed [15:0] dro;
   logic [1:0] modes [3] = '{tcs_pkg::TRQ_SPEED, tcs_pkg::TRQ_CURRENT, tcs_pkg::TRQ_TORQUE};
   int fails = 0, checks_done = 0;
   int k, thr, fm, lf, lr, ld;
   // Clock of 5 ns period.
   always #2.5 clk = ~clk;
   tcs_torque_control_supervisor i_dut (.i_clk_sys(clk), .i_sys_rst(rst), .i_avs_address(adr),
      .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdat), .o_avs_readdata(rdat),
      .o_avs_waitrequest(wreq), .i_run_forward_input(run_forward_input), .i_run_reverse_input(run_reverse_input),
      .i_torque_cancel_input(cncl), .i_torque_cmd_negative(neg), .i_output_freq(ofr),
      .i_thermistor_input_terminal(vth), .i_motor_temp(temp), .i_motor_select(msel),
      .i_load_torque_pct(load), .i_search_done(sdone), .i_search_freq(sfr),
      .o_drive_enable(drv), .o_torque_control(tctl), .o_torque_positive(tpos),
      .o_ramp_bypass(rbyp), .o_search_request(sreq), .o_start_freq(sfo),
      .o_overspeed_fault(ovs), .o_motor_protection_alarm(alm),
      .o_motor_overheat_output(heat), .o_droop_offset(dro), .o_irq(irq));
   tcs_motor_model i_motor (.i_clk_sys(clk), .i_sys_rst(rst), .i_search_request(sreq),
      .i_speed(spd), .i_rp_ohm(rp), .i_delay(dly), .o_therm_volt(vth), .o_output_freq(ofr),
      .o_search_done(sdone), .o_search_freq(sfr));
   // Expected overspeed level in 0.01 Hz from max frequency and limit percent.
   function automatic int thr_f(input int f, input int l);
      return (f * l * 120) / 10000;
   endfunction : thr_f
   // Prints the counts and the verdict, then ends the run.
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : wrap_up
   task automatic fin(input string nm);
      $display("test %0s finished", nm);
   endtask : fin
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   task automatic run(input logic f, input logic r);
      @(posedge clk);
      run_forward_input <= f;
      run_reverse_input <= r;
   endtask : run
   // One Avalon access held until waitrequest is sampled low; read data lands in q.
   task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      adr <= a;
      wdat <= d;
      wr <= w;
      rd <= !w;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (wreq !== 1'b0 && n < 50);
      q = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
      if (n >= 50) begin
         fails++;
         $display("Error at %0t: bus access never answered", $time);
         wrap_up();
      end
   endtask : bus
   // One thermistor case: mode, motor, resistance, temperature and expected trip or warning.
   task automatic thm_case(input logic [1:0] m, input logic [1:0] ms, input logic [15:0] r,
                           input logic [7:0] t, input logic ea, input logic eh);
      bus(1'b1, tcs_pkg::OFS_MODE, 32'({m, tcs_pkg::TRQ_TORQUE}));
      run(1'b1, 1'b0);
      msel <= ms;
      rp <= r;
      temp <= t;
      tick(4);
      `CHK(alm, ea)
      `CHK(heat, eh)
      `CHK(drv, !ea)
      run(1'b0, 1'b0);
      rp <= 16'h0;
      temp <= 8'h00;
      bus(1'b1, tcs_pkg::OFS_IRQ_CLR, 32'h6);
      tick(1);
      `CHK(alm, 1'b0)
   endtask : thm_case
   // Main sequence of tests.
   initial begin
      k = $urandom(32'h88e84622);
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      tick(1);
      `CHK(tpos, 1'b1)
      bus(1'b0, tcs_pkg::OFS_FMAX, 32'h0);
      `CHK(q[15:0], tcs_pkg::FMAX_RST)
      bus(1'b0, tcs_pkg::OFS_SPDLIM, 32'h0);
      `CHK(q[15:0], {tcs_pkg::LIM_RST, tcs_pkg::LIM_RST})
      bus(1'b0, tcs_pkg::OFS_THLVL, 32'h0);
      `CHK({q[23:16], q[8:0]}, {tcs_pkg::PROT_RST, tcs_pkg::THL_RST})
      bus(1'b0, 6'h24, 32'h0);
      `CHK(q, 32'h0)
      bus(1'b1, tcs_pkg::OFS_THLVL, 32'h0000_01ff);
      bus(1'b0, tcs_pkg::OFS_THLVL, 32'h0);
      `CHK(q[8:0], tcs_pkg::THL_MAX)
      fin("registers");
      // Every control mode with and without the cancel input, started and stopped.
      foreach (modes[i]) for (int c = 0; c < 2; c++) begin
         bus(1'b1, tcs_pkg::OFS_MODE, 32'({c[1:0], 2'h0, modes[i]}));
         run(1'b1, 1'b0);
         cncl <= c[0];
         tick(3);
         `CHK(tctl, (modes[i] != tcs_pkg::TRQ_SPEED) && !c[0])
         `CHK(rbyp, (modes[i] != tcs_pkg::TRQ_SPEED) && !c[0])
         `CHK(drv, 1'b1)
         `CHK(sfo, 16'h0)
         run(1'b0, 1'b0);
         tick(1);
         `CHK(drv, 1'b0)
      end
      cncl <= 1'b0;
      fin("modes");
      // Torque polarity over alternating direction and random command sign.
      for (int i = 0; i < 8; i++) begin
         run(i[0], !i[0]);
         neg <= 1'($urandom);
         tick(2);
         `CHK(tpos, neg ^ i[0])
      end
      run(1'b0, 1'b0);
      tick(2);
      fin("polarity");
      // Start with speed search, a quick and a slow estimator.
      bus(1'b1, tcs_pkg::OFS_IRQ_EN, 32'h8);
      bus(1'b1, tcs_pkg::OFS_MODE, 32'({tcs_pkg::SRCH_ALWAYS, 2'h0, tcs_pkg::TRQ_TORQUE}));
      for (int i = 0; i < 2; i++) begin
         run(1'b1, 1'b0);
         dly <= i[0] ? 8'd40 : 8'd1;
         spd <= 16'($urandom % 7000);
         tick(2);
         `CHK(sreq, 1'b1)
         `CHK(drv, 1'b0)
         for (k = 0; k < 100 && drv !== 1'b1; k++) tick(1);
         `CHK(drv, 1'b1)
         if (k == 100) wrap_up();
         `CHK(sfo, spd)
         `CHK(sreq, 1'b0)
         `CHK(tctl, 1'b1)
         `CHK(irq, 1'b1)
         bus(1'b0, tcs_pkg::OFS_IRQ_STAT, 32'h0);
         `CHK(q[tcs_pkg::EV_SRCH], 1'b1)
         bus(1'b1, tcs_pkg::OFS_IRQ_CLR, 32'h8);
         tick(1);
         `CHK(irq, 1'b0)
         run(1'b0, 1'b0);
         spd <= 16'h0;
         tick(2);
      end
      fin("search");
      // Overspeed at and just above the level, both directions, interrupt masked.
      bus(1'b1, tcs_pkg::OFS_IRQ_EN, 32'h0);
      bus(1'b1, tcs_pkg::OFS_MODE, 32'(tcs_pkg::TRQ_TORQUE));
      for (int i = 0; i < 6; i++) begin
         fm = 1000 + $urandom % 8000;
         lf = 1 + $urandom % 100;
         lr = 1 + $urandom % 100;
         bus(1'b1, tcs_pkg::OFS_FMAX, 32'(fm));
         bus(1'b1, tcs_pkg::OFS_SPDLIM, 32'({lr[7:0], lf[7:0]}));
         thr = thr_f(fm, i[0] ? lr : lf);
         run(!i[0], i[0]);
         spd <= 16'(thr);
         tick(3);
         `CHK(ovs, 1'b0)
         @(posedge clk);
         spd <= 16'(thr + 1);
         tick(3);
         `CHK(ovs, 1'b1)
         `CHK(drv, 1'b0)
         `CHK(irq, 1'b0)
         bus(1'b0, tcs_pkg::OFS_IRQ_STAT, 32'h0);
         `CHK(q[tcs_pkg::EV_OVS], 1'b1)
         run(1'b0, 1'b0);
         spd <= 16'h0;
         bus(1'b1, tcs_pkg::OFS_IRQ_CLR, 32'h1);
         tick(1);
         `CHK(ovs, 1'b0)
      end
      fin("overspeed");
      // Level for an alarm resistance of 1500 ohm gives 55, 3000 ohm gives 105.
      bus(1'b1, tcs_pkg::OFS_THLVL, {8'h00, 8'd100, 7'h00, 9'd55});
      thm_case(tcs_pkg::THM_OFF, 2'h0, 16'd3000, 8'd200, 1'b0, 1'b0);
      thm_case(tcs_pkg::THM_TRIP, 2'h0, 16'd1500, 8'd0, 1'b0, 1'b0);
      thm_case(tcs_pkg::THM_TRIP, 2'h2, 16'd3000, 8'd0, 1'b1, 1'b0);
      thm_case(tcs_pkg::THM_WARN, 2'h3, 16'd3000, 8'd0, 1'b0, 1'b1);
      thm_case(tcs_pkg::THM_NTC, 2'h0, 16'd0, 8'd101, 1'b1, 1'b0);
      thm_case(tcs_pkg::THM_NTC, 2'h0, 16'd0, 8'd100, 1'b0, 1'b0);
      thm_case(tcs_pkg::THM_NTC, 2'h1, 16'd0, 8'd200, 1'b0, 1'b0);
      fin("thermistor");
      // Droop range clamp, then offset against random load.
      bus(1'b1, tcs_pkg::OFS_DROOP, 32'h544);
      bus(1'b0, tcs_pkg::OFS_DROOP, 32'h0);
      `CHK(q[10:0], 11'h5a8)
      for (int i = 0; i < 5; i++) begin
         k = (i == 4) ? 0 : 1 + $urandom % 6;
         ld = $urandom % 101;
         bus(1'b1, tcs_pkg::OFS_DROOP, 32'(-100 * k));
         @(posedge clk);
         load <= 8'(ld);
         tick(3);
         `CHK(dro, 16'(-(k * ld)))
      end
      fin("droop");
      wrap_up();
   end
endmodule : testbench
`default_nettype wire
